// File: verilog/mcb_cmd.sv
// Command interpreter for DAC word, sequence and system configuration block transfers
// ----------------------------------------------------------------------------
// How it works
// RL1: Each margining DAC holds a two-byte word exchanged by DAC block transfers.
// RL2: Bits 10:6 pick the supervised input driving closed-loop margining; zero is none.
// RL3: Loop bit zero keeps closed-loop regulation running continuously.
// RL4: Loop bit one regulates to the setpoint, then halts adjustment.
// RL5: Bits 1:0 select off, open loop, closed loop; code three acts as off.
// RL6: Code 0xD6 is the sequence image block, readable and writable.
// RL7: Code 0xD7 is the system image block, readable and writable.
// RL8: Host read parameters are three bytes: length, offset low, offset high.
// RL9: Offset is sixteen bits, low byte first, and sets the image start.
// RL10: Sequence read returns length byte then data; length at most 252, multiple of 4.
// RL11: System read returns length byte then data; length at most 252, multiple of 4.
// RL12: Host write sends byte count, offset low, offset high, then payload.
// RL13: Sequence write ends at byte 250 at most; payload multiple of 4.
// RL14: System write ends at byte 250 at most; payload multiple of 4.
// RL15: DAC read with index 0xFF returns the words of all DACs.
// RL16: Transfers breaking length limits are dropped, flagged, and change nothing; overrunning or short writes keep bytes already written.
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "mcb_params.svh"
module mcb_cmd #(
  parameter int NDAC = `MCB_NDAC
) (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              cmd_start,
  input  wire logic [7:0]                        cmd_code,
  input  wire logic                              rx_valid,
  input  wire logic [7:0]                        rx_data,
  input  wire logic                              rd_start,
  input  wire logic                              tx_req,
  input  wire logic                              xfer_end,
  input  wire logic [7:0]                        img_rdata,
  input  wire logic [NDAC-1:0]                   at_setpoint,
  output logic                                   tx_valid,
  output logic [7:0]                             tx_data,
  output logic                                   img_wr,
  output logic                                   img_rd,
  output logic                                   img_sys,
  output logic [15:0]                            img_addr,
  output logic [7:0]                             img_wdata,
  output logic                                   comm_err,
  output mcb_pkg::mcb_dac_ctrl_s [NDAC-1:0]      dac_ctrl
);
  mcb_pkg::mcb_st_s s_ff;
  mcb_pkg::mcb_st_s nxt_s;
  logic [15:0] dac_words [NDAC];
  logic [7:0]  k;
  logic [3:0]  dn;

  // ----------------------------------------------------------------------------
  // Length checks
  // ----------------------------------------------------------------------------
  function automatic logic wr_len_ok(input mcb_pkg::mcb_kind_e kd, input logic [7:0] n);
    logic [7:0] pl;
    pl = n - 8'h02;
    if (kd == mcb_pkg::K_DAC)
      return n >= `MCB_DAC_WRMIN && n <= `MCB_DAC_WRMAX && n[0];
    else
      return n >= `MCB_IMG_WRMIN && n <= `MCB_IMG_WRMAX && pl[1:0] == 2'h0; // RL13 RL14
  endfunction

  function automatic logic [7:0] par_len(input mcb_pkg::mcb_kind_e kd);
    return (kd == mcb_pkg::K_DAC) ? `MCB_DAC_PARLEN : `MCB_IMG_PARLEN;
  endfunction

  // ----------------------------------------------------------------------------
  // DAC words
  // ----------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NDAC; g++)
    begin : g_dac
      mcb_dac_word u_word (
        .clk         (clk),
        .rst         (rst),
        .wr_en       (s_ff.dac_wr && s_ff.dac_wr_idx == 4'(g)),
        .wr_word     (s_ff.dac_wdata),
        .at_setpoint (at_setpoint[g]),
        .word        (dac_words[g]),
        .ctrl        (dac_ctrl[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Command state machine
  // ----------------------------------------------------------------------------
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.tx_valid = 1'b0;
    nxt_s.img_wr = 1'b0;
    nxt_s.img_rd = 1'b0;
    nxt_s.comm_err = 1'b0;
    nxt_s.dac_wr = 1'b0;
    k = s_ff.tpos - 8'h01;
    dn = ((s_ff.dsel == `MCB_DAC_ALL) ? 4'h0 : s_ff.dsel[3:0]) + k[4:1];
    if (s_ff.pend)
    begin
      nxt_s.pend = 1'b0;
      nxt_s.tx_valid = 1'b1;
      nxt_s.tx_data = img_rdata;
    end
    case (s_ff.st)
      mcb_pkg::ST_COUNT:
        if (rx_valid)
        begin
          nxt_s.cnt = rx_data;
          nxt_s.idx = 8'h00;
          if (rx_data == par_len(s_ff.kind))
            nxt_s.st = mcb_pkg::ST_PARAM;
          else if (wr_len_ok(s_ff.kind, rx_data))
            nxt_s.st = mcb_pkg::ST_WRITE;
          else
          begin
            nxt_s.st = mcb_pkg::ST_DROP; // RL16
            nxt_s.comm_err = 1'b1;
          end
        end
      mcb_pkg::ST_PARAM:
        if (rx_valid)
        begin
          nxt_s.idx = s_ff.idx + 8'h01;
          if (s_ff.idx == 8'h00)
          begin
            nxt_s.rdlen = rx_data; // RL8
            nxt_s.dsel = rx_data;
          end
          else if (s_ff.idx == 8'h01)
            nxt_s.off[7:0] = rx_data; // RL9
          else if (s_ff.idx == 8'h02)
            nxt_s.off[15:8] = rx_data; // RL9
          if (s_ff.idx >= s_ff.cnt)
          begin
            nxt_s.st = mcb_pkg::ST_DROP;
            nxt_s.comm_err = 1'b1;
          end
        end
      mcb_pkg::ST_WRITE:
        if (rx_valid)
        begin
          nxt_s.idx = s_ff.idx + 8'h01;
          if (s_ff.idx == s_ff.cnt)
          begin
            nxt_s.st = mcb_pkg::ST_DROP;
            nxt_s.comm_err = 1'b1;
          end
          else if (s_ff.kind == mcb_pkg::K_DAC)
          begin
            if (s_ff.idx == 8'h00)
            begin
              nxt_s.dptr = rx_data[3:0];
              if (rx_data >= 8'(NDAC) || rx_data + (s_ff.cnt >> 1) > 8'(NDAC))
              begin
                nxt_s.st = mcb_pkg::ST_DROP; // RL16
                nxt_s.comm_err = 1'b1;
              end
            end
            else if (s_ff.idx[0])
              nxt_s.lowb = rx_data;
            else
            begin
              nxt_s.dac_wr = 1'b1; // RL1
              nxt_s.dac_wr_idx = s_ff.dptr;
              nxt_s.dac_wdata = {rx_data, s_ff.lowb};
              nxt_s.dptr = s_ff.dptr + 4'h1;
            end
          end
          else if (s_ff.idx == 8'h00)
            nxt_s.off[7:0] = rx_data; // RL12
          else if (s_ff.idx == 8'h01)
            nxt_s.off[15:8] = rx_data; // RL12
          else
          begin
            nxt_s.img_wr = 1'b1;
            nxt_s.img_addr = s_ff.off + 16'(s_ff.idx - 8'h02); // RL9
            nxt_s.img_wdata = rx_data;
          end
        end
      mcb_pkg::ST_READ:
        if (tx_req)
        begin
          nxt_s.tpos = s_ff.tpos + 8'h01;
          if (s_ff.tpos == 8'h00)
          begin
            nxt_s.tx_valid = 1'b1; // RL10 RL11
            nxt_s.tx_data = s_ff.rdlen;
          end
          else if (s_ff.tpos > s_ff.rdlen)
          begin
            nxt_s.tx_valid = 1'b1;
            nxt_s.tx_data = 8'h00;
          end
          else if (s_ff.kind == mcb_pkg::K_DAC)
          begin
            nxt_s.tx_valid = 1'b1;
            nxt_s.tx_data = (32'(dn) < NDAC) ? (k[0] ? dac_words[dn][15:8] : dac_words[dn][7:0]) : 8'h00;
          end
          else
          begin
            nxt_s.img_rd = 1'b1;
            nxt_s.pend = 1'b1;
            nxt_s.img_addr = s_ff.off + 16'(k);
          end
        end
      default:
        ;
    endcase
    if (rd_start)
    begin
      nxt_s.st = mcb_pkg::ST_READ;
      nxt_s.tpos = 8'h00;
      if (s_ff.st != mcb_pkg::ST_PARAM || s_ff.idx != s_ff.cnt)
      begin
        nxt_s.rdlen = 8'h00;
        nxt_s.comm_err = 1'b1;
      end
      else if (s_ff.kind == mcb_pkg::K_DAC)
      begin
        if (s_ff.dsel == `MCB_DAC_ALL)
          nxt_s.rdlen = 8'(2 * NDAC); // RL15
        else if (s_ff.dsel < 8'(NDAC))
          nxt_s.rdlen = 8'h02;
        else
        begin
          nxt_s.rdlen = 8'h00;
          nxt_s.comm_err = 1'b1;
        end
      end
      else if (s_ff.rdlen > `MCB_IMG_RDMAX || s_ff.rdlen[1:0] != 2'h0)
      begin
        nxt_s.rdlen = 8'h00; // RL16
        nxt_s.comm_err = 1'b1;
      end
    end
    if (xfer_end)
    begin
      nxt_s.st = mcb_pkg::ST_IDLE;
      if ((s_ff.st == mcb_pkg::ST_WRITE || s_ff.st == mcb_pkg::ST_PARAM) && s_ff.idx != s_ff.cnt)
        nxt_s.comm_err = 1'b1;
    end
    if (cmd_start)
    begin
      nxt_s.st = mcb_pkg::ST_COUNT;
      if (cmd_code == `MCB_CMD_SEQ)
      begin
        nxt_s.kind = mcb_pkg::K_SEQ; // RL6
        nxt_s.img_sys = 1'b0;
      end
      else if (cmd_code == `MCB_CMD_SYS)
      begin
        nxt_s.kind = mcb_pkg::K_SYS; // RL7
        nxt_s.img_sys = 1'b1;
      end
      else if (cmd_code == `MCB_CMD_DAC)
        nxt_s.kind = mcb_pkg::K_DAC;
      else
        nxt_s.st = mcb_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign tx_valid = s_ff.tx_valid;
  assign tx_data = s_ff.tx_data;
  assign img_wr = s_ff.img_wr;
  assign img_rd = s_ff.img_rd;
  assign img_sys = s_ff.img_sys;
  assign img_addr = s_ff.img_addr;
  assign img_wdata = s_ff.img_wdata;
  assign comm_err = s_ff.comm_err;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  sequence s_len_req;
    s_ff.st == mcb_pkg::ST_READ && tx_req && s_ff.tpos == 8'h00 && !cmd_start && !rd_start && !xfer_end;
  endsequence
  property p_seq_rdlen;
    @(posedge clk) disable iff (rst) s_len_req ##0 (s_ff.kind == mcb_pkg::K_SEQ)
      |=> tx_valid && tx_data <= 8'hfc && tx_data[1:0] == 2'h0;
  endproperty
  a_seq_rdlen: assert property (p_seq_rdlen) else $error("Bad sequence read length"); // RL10
  property p_sys_rdlen;
    @(posedge clk) disable iff (rst) s_len_req ##0 (s_ff.kind == mcb_pkg::K_SYS)
      |=> tx_valid && tx_data <= 8'hfc && tx_data[1:0] == 2'h0;
  endproperty
  a_sys_rdlen: assert property (p_sys_rdlen) else $error("Bad system read length"); // RL11
  property p_dec_seq;
    @(posedge clk) disable iff (rst) cmd_start && cmd_code == 8'hd6 |=> s_ff.kind == mcb_pkg::K_SEQ && !img_sys;
  endproperty
  a_dec_seq: assert property (p_dec_seq) else $error("0xD6 not decoded"); // RL6
  property p_dec_sys;
    @(posedge clk) disable iff (rst) cmd_start && cmd_code == 8'hd7 |=> s_ff.kind == mcb_pkg::K_SYS && img_sys;
  endproperty
  a_dec_sys: assert property (p_dec_sys) else $error("0xD7 not decoded"); // RL7
  property p_drop;
    @(posedge clk) disable iff (rst) s_ff.st == mcb_pkg::ST_DROP |-> !img_wr && !s_ff.dac_wr;
  endproperty
  a_drop: assert property (p_drop) else $error("Dropped transfer changed config"); // RL16
  property p_all;
    @(posedge clk) disable iff (rst) rd_start && !cmd_start && !xfer_end && s_ff.st == mcb_pkg::ST_PARAM
      && s_ff.kind == mcb_pkg::K_DAC && s_ff.idx == s_ff.cnt && s_ff.dsel == 8'hff |=> s_ff.rdlen == 8'(2 * NDAC);
  endproperty
  a_all: assert property (p_all) else $error("All-DAC read length wrong"); // RL15
  property p_first_addr;
    @(posedge clk) disable iff (rst) s_ff.st == mcb_pkg::ST_WRITE && s_ff.kind != mcb_pkg::K_DAC && rx_valid
      && s_ff.idx == 8'h02 && s_ff.cnt > 8'h02 && !cmd_start && !rd_start && !xfer_end |=> img_wr && img_addr == $past(s_ff.off);
  endproperty
  a_first_addr: assert property (p_first_addr) else $error("Payload not at offset"); // RL9
  property p_wr_limit;
    @(posedge clk) disable iff (rst) s_ff.st == mcb_pkg::ST_WRITE && s_ff.kind != mcb_pkg::K_DAC
      |-> s_ff.cnt <= 8'hfa && s_ff.cnt[1:0] == 2'h2;
  endproperty
  a_wr_limit: assert property (p_wr_limit) else $error("Illegal write length accepted"); // RL13
endmodule
`default_nettype wire

// File: inc/mcb_params.svh
// Command codes, field positions and length limits of the margin/config block
`ifndef MCB_PARAMS_SVH
`define MCB_PARAMS_SVH
`define MCB_CMD_DAC      8'hd5
`define MCB_CMD_SEQ      8'hd6
`define MCB_CMD_SYS      8'hd7
`define MCB_NDAC         9
`define MCB_DAC_ALL      8'hff
`define MCB_DAC_PARLEN   8'h01
`define MCB_IMG_PARLEN   8'h03
`define MCB_IMG_RDMAX    8'hfc
`define MCB_IMG_WRMAX    8'hfa
`define MCB_IMG_WRMIN    8'h06
`define MCB_DAC_WRMIN    8'h03
`define MCB_DAC_WRMAX    8'h13
`define MCB_WORD_MASK    16'h07ff
`define MCB_SRC_HI       10
`define MCB_SRC_LO       6
`define MCB_SRC_MAX      5'h11
`define MCB_LOOP_BIT     5
`define MCB_MODE_HI      1
`define MCB_MODE_LO      0
`define MCB_MODE_OPEN    2'h1
`define MCB_MODE_CLOSED  2'h2
`endif

// File: inc/mcb_pkg.sv
// Types shared by the margin/config command block
package mcb_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_COUNT, ST_PARAM, ST_WRITE, ST_READ, ST_DROP} mcb_state_e;
  typedef enum logic [1:0] {K_DAC, K_SEQ, K_SYS} mcb_kind_e;
  typedef struct packed {
    logic [4:0] src;
    logic       open_loop;
    logic       closed_loop;
    logic       loop_run;
  } mcb_dac_ctrl_s;
  typedef struct packed {
    logic [15:0]   word;
    mcb_dac_ctrl_s ctrl;
  } mcb_dac_st_s;
  typedef struct packed {
    mcb_state_e st;
    mcb_kind_e  kind;
    logic [7:0] cnt;
    logic [7:0] idx;
    logic [15:0] off;
    logic [7:0] rdlen;
    logic [7:0] dsel;
    logic [7:0] lowb;
    logic [3:0] dptr;
    logic [7:0] tpos;
    logic       pend;
    logic       tx_valid;
    logic [7:0] tx_data;
    logic       img_wr;
    logic       img_rd;
    logic       img_sys;
    logic [15:0] img_addr;
    logic [7:0] img_wdata;
    logic       comm_err;
    logic       dac_wr;
    logic [3:0] dac_wr_idx;
    logic [15:0] dac_wdata;
  } mcb_st_s;
endpackage

// File: verilog/mcb_dac_word.sv
// One margining DAC configuration word and its decoded controls
`timescale 1ns/1ps
`default_nettype none
`include "mcb_params.svh"
module mcb_dac_word (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  wr_en,
  input  wire logic [15:0]           wr_word,
  input  wire logic                  at_setpoint,
  output logic [15:0]                word,
  output mcb_pkg::mcb_dac_ctrl_s     ctrl
);
  mcb_pkg::mcb_dac_st_s st_ff;
  mcb_pkg::mcb_dac_st_s nxt_st;
  logic [1:0] mode;
  logic [4:0] src;

  always_comb
  begin
    nxt_st = st_ff;
    if (wr_en)
    begin
      nxt_st.word = wr_word & `MCB_WORD_MASK; // RL1
    end
    src = nxt_st.word[`MCB_SRC_HI:`MCB_SRC_LO];
    mode = nxt_st.word[`MCB_MODE_HI:`MCB_MODE_LO];
    nxt_st.ctrl.src = (src > `MCB_SRC_MAX) ? 5'h00 : src; // RL2
    nxt_st.ctrl.open_loop = (mode == `MCB_MODE_OPEN); // RL5
    nxt_st.ctrl.closed_loop = (mode == `MCB_MODE_CLOSED); // RL5
    if (!nxt_st.ctrl.closed_loop)
    begin
      nxt_st.ctrl.loop_run = 1'b0;
    end
    else if (!nxt_st.word[`MCB_LOOP_BIT] || wr_en)
    begin
      nxt_st.ctrl.loop_run = 1'b1; // RL3
    end
    else if (at_setpoint)
    begin
      nxt_st.ctrl.loop_run = 1'b0; // RL4
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign word = st_ff.word;
  assign ctrl = st_ff.ctrl;

  property p_word_wr;
    @(posedge clk) disable iff (rst) wr_en |=> word == ($past(wr_word) & `MCB_WORD_MASK);
  endproperty
  a_word_wr: assert property (p_word_wr) else $error("DAC word not stored"); // RL1
  property p_src;
    @(posedge clk) disable iff (rst) word[10:6] <= 5'h11 |-> ctrl.src == word[10:6];
  endproperty
  a_src: assert property (p_src) else $error("Source select mismatch"); // RL2
  property p_loop_cont;
    @(posedge clk) disable iff (rst) (word[1:0] == 2'h2 && !word[5] && !wr_en) |=> ctrl.loop_run;
  endproperty
  a_loop_cont: assert property (p_loop_cont) else $error("Continuous loop stopped"); // RL3
  property p_loop_stop;
    @(posedge clk) disable iff (rst) (ctrl.loop_run && word[5] && at_setpoint && !wr_en) |=> !ctrl.loop_run;
  endproperty
  a_loop_stop: assert property (p_loop_stop) else $error("Loop did not halt at setpoint"); // RL4
  property p_mode_rsv;
    @(posedge clk) disable iff (rst) word[1:0] == 2'h3 |-> !ctrl.open_loop && !ctrl.closed_loop && !ctrl.loop_run;
  endproperty
  a_mode_rsv: assert property (p_mode_rsv) else $error("Reserved mode not off"); // RL5
endmodule
`default_nettype wire

// File: sim/mcb_host.sv
// Host controller model that drives the command byte stream
`timescale 1ns/1ps
`default_nettype none
module mcb_host (
  input  wire logic  clk,
  output logic       cmd_start,
  output logic [7:0] cmd_code,
  output logic       rx_valid,
  output logic [7:0] rx_data,
  output logic       rd_start,
  output logic       tx_req,
  output logic       xfer_end
);
  initial
  begin
    {cmd_start, rx_valid, rd_start, tx_req, xfer_end} = 5'h00;
    cmd_code = 8'h00;
    rx_data = 8'h00;
  end
  // ---------------------------------------------------------------------------
  // One strobe: 0 command, 1 byte, 2 read phase, 3 next byte, 4 stop
  // ---------------------------------------------------------------------------
  task automatic put(input logic [2:0] kind, input logic [7:0] b);
    @(negedge clk);
    {cmd_start, rx_valid, rd_start, tx_req, xfer_end} = 5'h10 >> kind;
    cmd_code = b;
    rx_data = b;
    @(negedge clk);
    {cmd_start, rx_valid, rd_start, tx_req, xfer_end} = 5'h00;
    // Released lines never keep a stale copy
    cmd_code = ~b;
    rx_data = ~b;
  endtask
endmodule
`default_nettype wire

// File: sim/mcb_cmd_tb.sv
// Self-checking testbench of the margin and configuration command block
`timescale 1ns/1ps
`default_nettype none
module mcb_cmd_tb;
  localparam int NDAC = 9;
  logic                              clk, rst, cmd_start, rx_valid, rd_start, tx_req, xfer_end;
  logic [7:0]                        cmd_code, rx_data, img_rdata, tx_data, img_wdata;
  logic [NDAC-1:0]                   at_setpoint;
  logic                              tx_valid, img_wr, img_rd, img_sys, comm_err;
  logic [15:0]                       img_addr, rnd, w;
  mcb_pkg::mcb_dac_ctrl_s [NDAC-1:0] dac_ctrl;
  logic [15:0]                       shadow [NDAC];
  int                                n_errors = 0, comparisons = 0, n_wr = 0, n_ce = 0, cycles = 0, d;

  mcb_cmd #(.NDAC(NDAC)) mcb_cmd_i (.clk(clk), .rst(rst), .cmd_start(cmd_start), .cmd_code(cmd_code),
    .rx_valid(rx_valid), .rx_data(rx_data), .rd_start(rd_start), .tx_req(tx_req), .xfer_end(xfer_end),
    .img_rdata(img_rdata), .at_setpoint(at_setpoint), .tx_valid(tx_valid), .tx_data(tx_data),
    .img_wr(img_wr), .img_rd(img_rd), .img_sys(img_sys), .img_addr(img_addr), .img_wdata(img_wdata),
    .comm_err(comm_err), .dac_ctrl(dac_ctrl));
  mcb_host mcb_host_i (.clk(clk), .cmd_start(cmd_start), .cmd_code(cmd_code), .rx_valid(rx_valid),
    .rx_data(rx_data), .rd_start(rd_start), .tx_req(tx_req), .xfer_end(xfer_end));

  // ---------------------------------------------------------------------------
  // Image store, clock, pulse counters and timeout
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] img_byte(input logic s, input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ {s, 7'h2b};
  endfunction
  assign img_rdata = img_byte(img_sys, img_addr);

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (img_wr === 1'b1) n_wr <= n_wr + 1;
    if (comm_err === 1'b1) n_ce <= n_ce + 1;
    if (cycles == 30000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic end_of_test;
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic void roll();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
  endfunction

  task automatic wr_img(input logic [7:0] code, input logic [7:0] cnt, input int nsend);
    logic [15:0] off;
    logic        good;
    int          w0, e0;
    roll();
    off = rnd;
    good = (code == 8'hd6 || code == 8'hd7)
      && cnt >= 8'h06 && cnt <= 8'hfa && ((cnt - 8'h02) & 8'h03) == 8'h00;
    w0 = n_wr;
    e0 = n_ce;
    mcb_host_i.put(3'h0, code);
    mcb_host_i.put(3'h1, cnt);
    mcb_host_i.put(3'h1, off[7:0]);
    mcb_host_i.put(3'h1, off[15:8]);
    for (int i = 0; i < nsend; i++)
    begin
      roll();
      mcb_host_i.put(3'h1, rnd[7:0]);
      if (good && i < cnt - 2)
        check("img_wr", {img_wr, img_sys, img_addr, img_wdata}, {1'b1, code == 8'hd7, off + 16'(i), rnd[7:0]});
    end
    mcb_host_i.put(3'h4, 8'h00);
    @(negedge clk);
    check("wr_count", n_wr - w0, good ? ((nsend < cnt - 2) ? nsend : cnt - 2) : 0);
    check("wr_err", n_ce != e0, (code == 8'hd6 || code == 8'hd7) && (!good || nsend != cnt - 2));
  endtask

  task automatic rd_img(input logic [7:0] code, input logic [7:0] len);
    logic [15:0] off;
    logic        good;
    int          e0;
    roll();
    off = rnd;
    good = len <= 8'hfc && len[1:0] == 2'h0;
    e0 = n_ce;
    mcb_host_i.put(3'h0, code);
    mcb_host_i.put(3'h1, 8'h03);
    mcb_host_i.put(3'h1, len);
    mcb_host_i.put(3'h1, off[7:0]);
    mcb_host_i.put(3'h1, off[15:8]);
    mcb_host_i.put(3'h2, 8'h00);
    mcb_host_i.put(3'h3, 8'h00);
    check("len_byte", {tx_valid, tx_data}, {1'b1, good ? len : 8'h00});
    for (int i = 0; i < (good ? len : 8'h00); i++)
    begin
      mcb_host_i.put(3'h3, 8'h00);
      check("img_rd", {img_rd, img_sys, img_addr}, {1'b1, code == 8'hd7, off + 16'(i)});
      @(negedge clk);
      check("rd_data", {tx_valid, tx_data}, {1'b1, img_byte(code == 8'hd7, off + 16'(i))});
    end
    mcb_host_i.put(3'h4, 8'h00);
    @(negedge clk);
    check("rd_err", n_ce != e0, !good);
  endtask

  task automatic rd_dac(input logic [7:0] sel);
    int n;
    n = (sel == 8'hff) ? NDAC : (sel < NDAC) ? 1 : 0;
    mcb_host_i.put(3'h0, 8'hd5);
    mcb_host_i.put(3'h1, 8'h01);
    mcb_host_i.put(3'h1, sel);
    mcb_host_i.put(3'h2, 8'h00);
    mcb_host_i.put(3'h3, 8'h00);
    check("dac_len", tx_data, 2 * n);
    for (int k = 0; k < 2 * n; k++)
    begin
      mcb_host_i.put(3'h3, 8'h00);
      check("dac_byte", {tx_valid, tx_data}, {1'b1, 8'(shadow[(n == 1) ? int'(sel) : k / 2] >> (8 * (k % 2)))});
    end
    mcb_host_i.put(3'h4, 8'h00);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    at_setpoint = '0;
    rnd = 16'h2a4e;
    foreach (shadow[i]) shadow[i] = 16'h0000;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    check("rst_out", {tx_valid, img_wr, img_rd, img_sys, comm_err, dac_ctrl === '0}, 6'h01);
    wr_img(8'hd6, 8'h06, 4);
    wr_img(8'hd7, 8'hfa, 248);
    wr_img(8'hd6, 8'h07, 5);
    wr_img(8'hd7, 8'hfe, 8);
    wr_img(8'hd6, 8'h0a, 4);
    wr_img(8'hd7, 8'h06, 5);
    wr_img(8'hd6, 8'h02, 0);
    wr_img(8'hd8, 8'h06, 4);
    rd_img(8'hd6, 8'h08);
    rd_img(8'hd7, 8'hfc);
    rd_img(8'hd6, 8'h0a);
    rd_img(8'hd7, 8'h04);
    for (int k = 0; k < 6; k++)
    begin
      roll();
      w = {rnd[15:11], rnd[10:6], k == 5, rnd[4:2], (k < 4) ? 2'(k) : 2'h2};
      roll();
      d = int'(rnd[3:0]) % NDAC;
      mcb_host_i.put(3'h0, 8'hd5);
      mcb_host_i.put(3'h1, 8'h03);
      mcb_host_i.put(3'h1, 8'(d));
      mcb_host_i.put(3'h1, w[7:0]);
      mcb_host_i.put(3'h1, w[15:8]);
      @(negedge clk);
      mcb_host_i.put(3'h4, 8'h00);
      shadow[d] = w & 16'h07ff;
      check("dac_ctrl", {dac_ctrl[d].src, dac_ctrl[d].open_loop, dac_ctrl[d].closed_loop},
            {((w[10:6] > 5'h11) ? 5'h00 : w[10:6]), w[1:0] == 2'h1, w[1:0] == 2'h2});
      if (k >= 4)
      begin
        check("loop_run", dac_ctrl[d].loop_run, 1'b1);
        at_setpoint[d] = 1'b1;
        repeat (3) @(negedge clk);
        check("loop_hold", dac_ctrl[d].loop_run, k == 4);
        at_setpoint[d] = 1'b0;
        repeat (3) @(negedge clk);
        check("loop_stop", dac_ctrl[d].loop_run, k == 4);
      end
    end
    rd_dac(8'(d));
    rd_dac(8'h09);
    rd_dac(8'hff);
    end_of_test();
  end
endmodule
`default_nettype wire
